// ---- design/mac_filter_params.svh ----
`ifndef MAC_FILTER_PARAMS_SVH
`define MAC_FILTER_PARAMS_SVH

// ==========================================
// Register byte addresses
`define OFF_STATION_ADDRESS_HIGH 9'h104
`define OFF_STATION_ADDRESS_LOW  9'h108
`define OFF_GROUP_HASH_UPPER     9'h10C
`define OFF_GROUP_HASH_LOWER     9'h110
`define OFF_PHY_MGMT_CONTROL     9'h114
`define OFF_PHY_MGMT_DATA        9'h118
`define OFF_FILTER_CONTROL       9'h100

// ==========================================
// Reset values
`define RST_STATION_ADDRESS_HIGH 16'hFFFF
`define RST_STATION_ADDRESS_LOW  32'hFFFFFFFF
`define RST_GROUP_HASH           32'h00000000
`define RST_PHY_MGMT_DATA        16'h0000

// ==========================================
// Management control and filter control fields
`define MGMT_PHY_ADDR_HI  15
`define MGMT_PHY_ADDR_LO  11
`define MGMT_REG_INDEX_HI 10
`define MGMT_REG_INDEX_LO 6
`define MGMT_WRITE_BIT    1
`define MGMT_BUSY_BIT     0
`define FILTER_ACCEPT_ALL_BIT 0

// ==========================================
// Management clock timing
`define MDC_PERIOD_NS    400
`define CLK_PERIOD_NS    100
`define MDC_HALF_CYCLES  ((`MDC_PERIOD_NS / `CLK_PERIOD_NS) / 2)
`define MDIO_FRAME_BITS  64

`endif

// ---- design/mac_filter_pkg.sv ----
package mac_filter_pkg;
   typedef enum logic [1:0] {
      mgmt_idle,
      mgmt_shift,
      mgmt_done
   } mgmt_state_t;
   typedef logic [5:0] hash_index_t;
endpackage : mac_filter_pkg

// ---- design/mgmt_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface mgmt_link_if;
   logic        start;
   logic        write;
   logic [4:0]  phy_addr;
   logic [4:0]  reg_index;
   logic [15:0] wdata;
   logic        done;
   logic [15:0] rdata;
   modport ctrl (output start, output write, output phy_addr, output reg_index, output wdata,
                 input done, input rdata);
   modport engine (input start, input write, input phy_addr, input reg_index, input wdata,
                   output done, output rdata);
endinterface : mgmt_link_if
`default_nettype wire

// ---- design/mgmt_frame_engine.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "mac_filter_params.svh"
module mgmt_frame_engine
   import mac_filter_pkg::*;
(
   input  wire logic    clk_i,
   input  wire logic    rst_i,
   mgmt_link_if.engine  link,
   output logic         mdc_o,
   output logic         mdio_o,
   output logic         mdio_oe_n_o,
   input  wire logic    mdio_i
);
   localparam logic [7:0] HALF = 8'(`MDC_HALF_CYCLES);
   mgmt_state_t state;
   logic [7:0]  div;
   logic [6:0]  bitn;
   logic [63:0] shreg;
   logic [15:0] rd;
   logic        s1, s2, s3;

   // ==========================================
   // Input synchroniser
   always_ff @(posedge clk_i) begin
      s1 <= mdio_i;
      s2 <= s1;
      s3 <= s2;
   end

   // ==========================================
   // Clause-22 frame shifter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state       <= mgmt_idle;
         div         <= 8'h00;
         bitn        <= 7'h00;
         shreg       <= 64'h0;
         rd          <= 16'h0000;
         mdc_o       <= 1'b0;
         mdio_o      <= 1'b1;
         mdio_oe_n_o <= 1'b1;
         link.done   <= 1'b0;
      end else begin
         link.done <= 1'b0;
         unique case (state)
            mgmt_idle: begin
               mdc_o <= 1'b0;
               if (link.start) begin
                  // Preamble, start, opcode, addresses, turnaround, data
                  shreg <= {32'hFFFFFFFF, 2'b01, link.write ? 2'b01 : 2'b10,
                            link.phy_addr, link.reg_index,
                            link.write ? 2'b10 : 2'b11,
                            link.write ? link.wdata : 16'hFFFF};
                  bitn  <= 7'h00;
                  div   <= 8'h00;
                  state <= mgmt_shift;
               end
            end
            mgmt_shift: begin
               div <= div + 8'h01;
               if (div == HALF - 8'h01) begin
                  mdc_o <= 1'b1;
               end else if (div == HALF + HALF - 8'h01) begin
                  // Sample late in the bit, once the synchroniser has settled
                  if (s2 == s3)
                     rd <= {rd[14:0], s3};
                  div    <= 8'h00;
                  mdc_o  <= 1'b0;
                  bitn   <= bitn + 7'h01;
                  if (bitn == 7'(`MDIO_FRAME_BITS) - 7'h01)
                     state <= mgmt_done;
               end
               if (div == 8'h00) begin
                  mdio_o      <= shreg[63];
                  shreg       <= {shreg[62:0], 1'b1};
                  // Release the line for turnaround and read data
                  mdio_oe_n_o <= link.write ? 1'b0 : (bitn >= 7'd46);
               end
            end
            mgmt_done: begin
               mdio_oe_n_o <= 1'b1;
               mdio_o      <= 1'b1;
               link.done   <= 1'b1;
               state       <= mgmt_idle;
            end
            default: state <= mgmt_idle;
         endcase
      end
   end

   // Read data is the last 16 bits sampled while the synchroniser was settled
   assign link.rdata = rd;
endmodule : mgmt_frame_engine
`default_nettype wire

// ---- design/mac_filter_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "mac_filter_params.svh"
module mac_filter_regs
   import mac_filter_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [8:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        rx_dest_valid_i,
   input  wire logic [47:0] rx_dest_addr_i,
   input  wire logic [5:0]  rx_hash_i,
   output logic             rx_addr_match_o,
   output logic             rx_group_accept_o,
   output logic             mdc_o,
   output logic             mdio_o,
   output logic             mdio_oe_n_o,
   input  wire logic        mdio_i
);
   logic [15:0] station_address_high;
   logic [31:0] station_address_low;
   logic [31:0] group_hash_upper;
   logic [31:0] group_hash_lower;
   logic [4:0]  phy_addr;
   logic [4:0]  phy_reg_index;
   logic        phy_write_select;
   logic        phy_access_busy;
   logic [15:0] phy_mgmt_data;
   logic        accept_all_group;
   logic        wr;
   logic [47:0] station;
   logic [31:0] next_rdata;
   mgmt_link_if link ();

   // ==========================================
   // Byte-lane merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction : merge

   function automatic logic hit(input logic [8:0] off);
      return wr && wb_adr_i == off;
   endfunction : hit

   // Write lands at the edge where the master sees ack high
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

   // ==========================================
   // Wishbone answer, one wait state
   always_ff @(posedge clk_i) begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
   end

   always_comb begin
      next_rdata = 32'h0;
      unique case (wb_adr_i)
         `OFF_FILTER_CONTROL:       next_rdata = {31'h0, accept_all_group};
         `OFF_STATION_ADDRESS_HIGH: next_rdata = {16'h0, station_address_high};
         `OFF_STATION_ADDRESS_LOW:  next_rdata = station_address_low;
         `OFF_GROUP_HASH_UPPER:     next_rdata = group_hash_upper;
         `OFF_GROUP_HASH_LOWER:     next_rdata = group_hash_lower;
         `OFF_PHY_MGMT_CONTROL:     next_rdata = {16'h0, phy_addr, phy_reg_index, 4'h0,
                                                  phy_write_select, phy_access_busy};
         `OFF_PHY_MGMT_DATA:        next_rdata = {16'h0, phy_mgmt_data};
         default:                   next_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         wb_dat_o <= 32'h0;
      else
         wb_dat_o <= next_rdata;
   end

   // ==========================================
   // Station address and hash table
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         station_address_high <= `RST_STATION_ADDRESS_HIGH;
         station_address_low  <= `RST_STATION_ADDRESS_LOW;
         group_hash_upper     <= `RST_GROUP_HASH;
         group_hash_lower     <= `RST_GROUP_HASH;
         accept_all_group     <= 1'b0;
      end else begin
         if (hit(`OFF_STATION_ADDRESS_HIGH))
            station_address_high <= 16'(merge({16'h0, station_address_high}, wb_dat_i, wb_sel_i));
         if (hit(`OFF_STATION_ADDRESS_LOW))
            station_address_low <= merge(station_address_low, wb_dat_i, wb_sel_i);
         if (hit(`OFF_GROUP_HASH_UPPER))
            group_hash_upper <= merge(group_hash_upper, wb_dat_i, wb_sel_i);
         if (hit(`OFF_GROUP_HASH_LOWER))
            group_hash_lower <= merge(group_hash_lower, wb_dat_i, wb_sel_i);
         if (hit(`OFF_FILTER_CONTROL) && wb_sel_i[0])
            accept_all_group <= wb_dat_i[`FILTER_ACCEPT_ALL_BIT];
      end
   end

   // ==========================================
   // Receive filter decisions
   // First received octet in bits 47:40 of rx_dest_addr_i
   assign station = {station_address_low[7:0], station_address_low[15:8],
                     station_address_low[23:16], station_address_low[31:24],
                     station_address_high[7:0], station_address_high[15:8]};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_addr_match_o   <= 1'b0;
         rx_group_accept_o <= 1'b0;
      end else begin
         rx_addr_match_o <= rx_dest_valid_i && rx_dest_addr_i == station;
         rx_group_accept_o <= rx_dest_valid_i && rx_dest_addr_i[40] &&
                              (accept_all_group ||
                               (rx_hash_i[5] ? group_hash_upper[rx_hash_i[4:0]]
                                             : group_hash_lower[rx_hash_i[4:0]]));
      end
   end

   // ==========================================
   // Management control and data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phy_addr         <= 5'h00;
         phy_reg_index    <= 5'h00;
         phy_write_select <= 1'b0;
         phy_access_busy  <= 1'b0;
      end else begin
         if (link.done)
            phy_access_busy <= 1'b0;
         if (hit(`OFF_PHY_MGMT_CONTROL) && !phy_access_busy) begin
            if (wb_sel_i[0]) begin
               phy_write_select <= wb_dat_i[`MGMT_WRITE_BIT];
               phy_access_busy  <= wb_dat_i[`MGMT_BUSY_BIT];
               phy_reg_index[1:0] <= wb_dat_i[7:6];
            end
            if (wb_sel_i[1]) begin
               phy_reg_index[4:2] <= wb_dat_i[`MGMT_REG_INDEX_HI:8];
               phy_addr <= wb_dat_i[`MGMT_PHY_ADDR_HI:`MGMT_PHY_ADDR_LO];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         phy_mgmt_data <= `RST_PHY_MGMT_DATA;
      else if (link.done && !phy_write_select)
         phy_mgmt_data <= link.rdata;
      else if (hit(`OFF_PHY_MGMT_DATA) && !phy_access_busy)
         phy_mgmt_data <= 16'(merge({16'h0, phy_mgmt_data}, wb_dat_i, wb_sel_i));
   end

   // Launch pulse on the busy bit rising
   always_ff @(posedge clk_i) begin
      if (rst_i)
         link.start <= 1'b0;
      else
         link.start <= hit(`OFF_PHY_MGMT_CONTROL) && !phy_access_busy &&
                       wb_sel_i[0] && wb_dat_i[`MGMT_BUSY_BIT];
   end

   assign link.write     = phy_write_select;
   assign link.phy_addr  = phy_addr;
   assign link.reg_index = phy_reg_index;
   assign link.wdata     = phy_mgmt_data;

   mgmt_frame_engine u_engine (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .link        (link),
      .mdc_o       (mdc_o),
      .mdio_o      (mdio_o),
      .mdio_oe_n_o (mdio_oe_n_o),
      .mdio_i      (mdio_i)
   );
endmodule : mac_filter_regs
`default_nettype wire

// ---- verif/mac_filter_regs_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "mac_filter_params.svh"
module mac_filter_regs_asserts (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [8:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        mdc_o,
   input wire logic        mdio_o,
   input wire logic        mdio_oe_n_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic [6:0] bits;
   logic [3:0] idle;
   logic       rdx;
   assign rdx = wb_ack_o && !wb_we_i;
   // ==========
   // Frame bit count, cleared after idle clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bits <= 7'h00;
         idle <= 4'h0;
      end else begin
         idle <= mdc_o ? 4'h0 : idle + {3'h0, idle != 4'hF};
         if ($rose(mdc_o)) begin
            bits <= bits + 7'h01;
         end else if (idle == 4'h8) begin
            bits <= 7'h00;
         end
      end
   end
   AST_ACK_LAT:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   AST_ACK_PULSE:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
   AST_HIGH_RSVD:
      assert property (rdx && wb_adr_i == `OFF_STATION_ADDRESS_HIGH |-> wb_dat_o[31:16] == 16'h0000)
      else $error("high word bits set");
   AST_DATA_RSVD:
      assert property (rdx && wb_adr_i == `OFF_PHY_MGMT_DATA |-> wb_dat_o[31:16] == 16'h0000)
      else $error("data bits set");
   AST_BUSY_SPAN:
      assert property (rdx && wb_adr_i == `OFF_PHY_MGMT_CONTROL && bits != 7'h00 && bits < 7'd64
         |-> wb_dat_o[0]) else $error("busy low in frame");
   AST_MDC_HIGH:
      assert property ($rose(mdc_o) |=> mdc_o ##1 !mdc_o) else $error("clock high time");
   AST_PREAMBLE:
      assert property ($rose(mdc_o) && bits < 7'd32 |-> mdio_o && !mdio_oe_n_o) else $error("preamble");
   AST_FRAME_LEN:
      assert property (idle == 4'h8 && bits != 7'h00 |-> bits == 7'd64) else $error("frame length");
endmodule : mac_filter_regs_asserts
bind mac_filter_regs mac_filter_regs_asserts asserts_u (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
   .mdc_o, .mdio_o, .mdio_oe_n_o
);
`default_nettype wire

// ---- verif/mgmt_phy_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module mgmt_phy_model #(
   parameter logic [15:0] READ_WORD = 16'h5AC3
) (
   input  wire logic   rst_i,
   input  wire logic   mdc_i,
   input  wire logic   dout_i,
   input  wire logic   oe_n_i,
   output logic        line_o,
   output logic [63:0] frame_o
);
   logic [63:0] sh;
   logic [6:0]  n;
   logic        drv;
   logic        bit_q;
   // Pull-up when nobody drives
   assign line_o = !oe_n_i ? dout_i : (drv ? bit_q : 1'b1);
   // ==========
   // Capture bits, answer reads after turnaround
   always @(posedge mdc_i or posedge rst_i) begin
      if (rst_i) begin
         n <= 7'h00;
      end else begin
         sh <= {sh[62:0], line_o};
         n <= (n == 7'd63) ? 7'h00 : n + 7'h01;
         if (n == 7'd63) begin
            frame_o <= {sh[62:0], line_o};
         end
      end
   end
   always @(negedge mdc_i or posedge rst_i) begin
      if (rst_i) begin
         drv <= 1'b0;
      end else begin
         drv <= (n == 7'd47) ? (sh[12] && !sh[11]) : (drv && n > 7'd47);
         bit_q <= (n == 7'd47) ? 1'b0 : READ_WORD[4'(7'd63 - n)];
      end
   end
endmodule : mgmt_phy_model
`default_nettype wire

// ---- verif/test_mac_filter_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "mac_filter_params.svh"
module test_mac_filter_regs;
   localparam logic [15:0] RD_WORD = 16'h5AC3;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic        dv = 1'b0;
   logic [8:0]  adr = 9'h000;
   logic [31:0] wd = 32'h0;
   logic [47:0] da = 48'h0;
   logic [5:0]  hs = 6'h00;
   logic [31:0] rd, dat_o, lo, up;
   logic        ack, match, gacc, mdc, mdo, oe_n, mdi;
   logic [63:0] frame;
   int          failures = 0;
   int          checks_done = 0;
   logic [8:0]  offs [6] = '{9'h104, 9'h108, 9'h10C, 9'h110, 9'h118, 9'h1FC};
   logic [31:0] rstv [6] = '{32'h0000FFFF, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [31:0] rwv [6] = '{32'h0000FFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0000FFFF, 32'h0};
   always #50 clk_i = ~clk_i;
   mac_filter_regs dut_u (
      .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack), .rx_dest_valid_i(dv),
      .rx_dest_addr_i(da), .rx_hash_i(hs), .rx_addr_match_o(match), .rx_group_accept_o(gacc),
      .mdc_o(mdc), .mdio_o(mdo), .mdio_oe_n_o(oe_n), .mdio_i(mdi)
   );
   mgmt_phy_model #(.READ_WORD(RD_WORD)) phy_u (
      .rst_i, .mdc_i(mdc), .dout_i(mdo), .oe_n_i(oe_n), .line_o(mdi), .frame_o(frame)
   );
   // ==========
   // Bus, filter and management tasks
   task automatic final_report();
      if (failures == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = dat_o;
      {cyc, stb} <= 2'b00;
      chk(n < 20, 1'b1);
      if (n >= 20) final_report();
   endtask : bus
   task automatic rx(input logic [47:0] a, input logic [5:0] h, input logic [1:0] exp);
      @(posedge clk_i);
      {dv, da, hs} <= {1'b1, a, h};
      repeat (2) @(posedge clk_i);
      chk({match, gacc}, exp);
      dv <= 1'b0;
   endtask : rx
   task automatic mgmt(input logic [31:0] ctl);
      int n;
      bus(1'b1, `OFF_PHY_MGMT_CONTROL, ctl);
      bus(1'b0, `OFF_PHY_MGMT_CONTROL, 32'h0);
      chk(rd[0], 1'b1);
      // Data write while busy must be dropped
      bus(1'b1, `OFF_PHY_MGMT_DATA, 32'h0);
      n = 0;
      do begin
         bus(1'b0, `OFF_PHY_MGMT_CONTROL, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 200);
      chk(rd, ctl & 32'h0000FFFE);
      if (n >= 200) final_report();
   endtask : mgmt
   // ==========
   // Sequence
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, offs[i], 32'h0);
         chk(rd, rstv[i]);
         bus(1'b1, offs[i], 32'hFFFFFFFF);
         bus(1'b0, offs[i], 32'h0);
         chk(rd, rwv[i]);
      end
      bus(1'b0, `OFF_PHY_MGMT_CONTROL, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, `OFF_STATION_ADDRESS_LOW, 32'h78563412);
      bus(1'b1, `OFF_STATION_ADDRESS_HIGH, 32'h0000BC9A);
      rx(48'h123456789ABC, 6'h00, 2'b10);
      rx(48'h123456789ABD, 6'h00, 2'b00);
      rx(48'h133456789ABC, 6'h00, 2'b01);
      lo = 32'h80000001;
      up = 32'h80000003;
      bus(1'b1, `OFF_GROUP_HASH_LOWER, lo);
      bus(1'b1, `OFF_GROUP_HASH_UPPER, up);
      for (int i = 0; i < 64; i++) begin
         rx(48'h010000000000, 6'(i), {1'b0, i[5] ? up[i[4:0]] : lo[i[4:0]]});
      end
      bus(1'b1, `OFF_FILTER_CONTROL, 32'h1);
      rx(48'h010000000000, 6'h01, 2'b01);
      bus(1'b1, `OFF_PHY_MGMT_DATA, 32'h0000A5C3);
      mgmt(32'h00000943);
      chk(frame, {32'hFFFFFFFF, 4'b0101, 5'd1, 5'd5, 2'b10, 16'hA5C3});
      bus(1'b0, `OFF_PHY_MGMT_DATA, 32'h0);
      chk(rd, 32'h0000A5C3);
      mgmt(32'h00000A41);
      chk(frame, {32'hFFFFFFFF, 4'b0110, 5'd1, 5'd9, 2'b10, RD_WORD});
      bus(1'b0, `OFF_PHY_MGMT_DATA, 32'h0);
      chk(rd, {16'h0, RD_WORD});
      final_report();
   end
endmodule : test_mac_filter_regs
`default_nettype wire
